//--- rif_pkg.sv
// Shared constants and carrier types for the remappable interrupt source controller.
// Assumes a single 50 MHz clock domain and an APB slave with 32-bit data.
package rif_pkg;

  // Register byte offsets of the controller's own APB map.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_VECTOR = 8'h08;
  localparam logic [7:0] ADDR_SEND = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_REDIR_LO = 8'h14;
  localparam logic [7:0] ADDR_REDIR_HI = 8'h18;
  localparam logic [7:0] ADDR_MSI_ADDR = 8'h1c;
  localparam logic [7:0] ADDR_MSI_DATA = 8'h20;

  // Reset values of the writable registers.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  // Entry encoded from the reset settings: only the remappable-format bit is set.
  localparam logic [63:0] ENTRY_RESET = 64'h0001_0000_0000_0000;

  // Field positions in the control register.
  localparam int CTRL_MSI_BIT = 0;
  localparam int CTRL_ENC_LSB = 1;
  localparam int CTRL_LOG2N_LSB = 3;
  localparam int CTRL_TRIG_BIT = 6;
  localparam int CTRL_MASK_BIT = 7;
  localparam int CTRL_BCAST_BIT = 8;

  // Field positions in the status register.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_CNT_LSB = 8;

  // Redirection entry layout in remappable format.
  localparam int RE_INDEX_LSB = 49;
  localparam int RE_INDEX15_BIT = 11;
  localparam int RE_FORMAT_BIT = 48;
  localparam int RE_DELIV_LSB = 8;
  localparam int RE_TRIG_BIT = 15;
  localparam int RE_MASK_BIT = 16;
  localparam logic [2:0] RE_DELIV_FIXED = 3'h0;

  // Message address layout in remappable format.
  localparam logic [11:0] MSG_ID = 12'hfee;
  localparam int MSG_ID_LSB = 20;
  localparam int MSG_INDEX_LSB = 5;
  localparam int MSG_INDEX15_BIT = 2;
  localparam int MSG_FORMAT_BIT = 4;
  localparam int MSG_SUBVALID_BIT = 3;

  // Largest multi-vector count is 32, so log2 of it is 5.
  localparam logic [2:0] MAX_LOG2N = 3'h5;

  // How the remap index is carried in handle and subhandle.
  typedef enum logic [1:0] {
    RIF_ENC_HANDLE = 2'b00,
    RIF_ENC_SUB = 2'b01,
    RIF_ENC_MULTI = 2'b10,
    RIF_ENC_BAD = 2'b11
  } rif_enc_type;

  // Settings that shape the encoding.
  typedef struct packed {
    logic msi;
    rif_enc_type enc;
    logic [2:0] log2n;
    logic trig;
    logic mask;
    logic msg_bcast;
    logic [15:0] index;
    logic [7:0] vector;
  } rif_cfg_type;

  // One doubleword interrupt write.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } rif_req_type;

endpackage

//--- rif_encoder.sv
// Combinational encoder that builds the redirection entry and the message address and data.
// Assumes its settings come from registers of the main controller on the same clock; the relative number may come straight from the bus.
`timescale 1ns/10ps
module rif_encoder (
  input wire rif_pkg::rif_cfg_type cfg,
  input wire logic [4:0] rel,
  output logic [63:0] entry,
  output rif_pkg::rif_req_type msg,
  output logic cfg_err
);

  // Local copy of the index position so the part-select base is a plain constant.
  localparam int RE_INDEX_LSB_W = rif_pkg::RE_INDEX_LSB;

  // Index carried by handle and subhandle.
  logic [15:0] handle;
  logic [15:0] sub;
  logic [5:0] count;
  logic [16:0] last;

  // Build the entry and the one message form that the settings select.
  always_comb begin
    entry = 64'h0;
    entry[RE_INDEX_LSB_W +: 15] = cfg.index[14:0];
    entry[rif_pkg::RE_INDEX15_BIT] = cfg.index[15];
    entry[rif_pkg::RE_FORMAT_BIT] = 1'b1;
    entry[rif_pkg::RE_DELIV_LSB +: 3] = rif_pkg::RE_DELIV_FIXED;
    entry[rif_pkg::RE_TRIG_BIT] = cfg.trig;
    entry[rif_pkg::RE_MASK_BIT] = cfg.mask;
    entry[7:0] = cfg.vector;
    count = 6'h01 << cfg.log2n;
    last = {1'b0, cfg.index} + {11'h0, count} - 17'h00001;
    handle = cfg.index;
    sub = 16'h0;
    cfg_err = 1'b0;
    unique case (cfg.enc)
      rif_pkg::RIF_ENC_HANDLE: begin
        // Handle holds the index, subhandle is zero.
        cfg_err = rel != 5'h00;
      end
      rif_pkg::RIF_ENC_SUB: begin
        // Handle is zero and subhandle holds the index.
        handle = 16'h0;
        sub = cfg.index;
        cfg_err = rel != 5'h00;
      end
      rif_pkg::RIF_ENC_MULTI: begin
        // Handle names the first of N reserved entries; the source carries the relative number in the subhandle.
        sub = {11'h0, rel};
        cfg_err = (cfg.log2n > rif_pkg::MAX_LOG2N) || ({1'b0, rel} >= count) || last[16];
      end
      default: begin
        // Code three has no meaning and is refused.
        cfg_err = 1'b1;
      end
    endcase
    if (cfg.msi) begin
      msg.addr = 32'h0;
      msg.addr[rif_pkg::MSG_ID_LSB +: 12] = rif_pkg::MSG_ID;
      msg.addr[rif_pkg::MSG_INDEX_LSB +: 15] = handle[14:0];
      msg.addr[rif_pkg::MSG_INDEX15_BIT] = handle[15];
      msg.addr[rif_pkg::MSG_FORMAT_BIT] = 1'b1;
      msg.addr[rif_pkg::MSG_SUBVALID_BIT] = 1'b1;
      msg.data = {16'h0, sub};
    end else begin
      // A router entry always sends with the subhandle-valid flag clear.
      msg.addr = 32'h0;
      msg.addr[rif_pkg::MSG_ID_LSB +: 12] = rif_pkg::MSG_ID;
      msg.addr[rif_pkg::MSG_INDEX_LSB +: 15] = entry[RE_INDEX_LSB_W +: 15];
      msg.addr[rif_pkg::MSG_INDEX15_BIT] = entry[rif_pkg::RE_INDEX15_BIT];
      msg.addr[rif_pkg::MSG_FORMAT_BIT] = entry[rif_pkg::RE_FORMAT_BIT];
      msg.addr[rif_pkg::MSG_SUBVALID_BIT] = |entry[rif_pkg::RE_DELIV_LSB +: 3];
      msg.data = {24'h0, entry[7:0]};
      // Only the plain handle form exists for a router; a relative number is refused too.
      cfg_err = cfg_err || (cfg.enc != rif_pkg::RIF_ENC_HANDLE);
    end
  end

endmodule // rif_encoder

//--- rif_source_ctrl.sv
// Interrupt source controller: programs a remappable redirection entry or message address
// and data, and sends doubleword interrupt writes to the remapping hardware.
// Assumes software on APB, and a remapping port on the same clock with a valid/ready handshake.
//
// Notes on behaviour
// - Index carried in one of three ways.
// - Entry bits 63:49 and 11 hold index.
// - Entry bit 48 marks remappable format.
// - Entry bits 10:8 zero, flag clear.
// - Entry trigger bit equals remap entry trigger.
// - Level entries with broadcast share remap vector.
// - Message address top bits hold FEEh.
// - Index in address 19:5 and bit 2.
// - Multi-vector: up to 32, consecutive entries.
// - Source drives relative number in data.
// - Address bit 4 marks remappable format.
// - Address bit 3 sets subhandle-valid flag.
// - Data zero except owned low bits.
// - Other entry fields keep ordinary meaning.
`timescale 1ns/10ps
module rif_source_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic [31:0] req_data,
  input wire logic req_ready
);

  // Software settings and their next values.
  rif_pkg::rif_cfg_type cfg_reg, cfg_next;
  // Pending request and its next value.
  rif_pkg::rif_req_type req_reg, req_next;
  logic req_valid_reg, req_valid_next;
  // Sticky error flag and count of completed sends.
  logic err_reg, err_next;
  logic [7:0] sent_reg, sent_next;
  // Registered read data and slave error.
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  // Registered copy of the encoded entry, shown to software.
  logic [63:0] entry_reg, entry_next;
  // Encoder outputs for the current settings and relative number.
  logic [63:0] enc_entry;
  rif_pkg::rif_req_type enc_msg;
  logic enc_err;
  rif_pkg::rif_req_type view_msg;
  logic view_err;
  // Relative number of a multi-vector send, taken from the write data.
  logic [4:0] send_rel;

  // Bus phase decode: setup phase prepares read data, access phase commits writes.
  logic setup_phase;
  logic access_phase;
  logic wr_send;
  logic mapped;
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_send = access_phase && pwrite && (paddr == rif_pkg::ADDR_SEND);
  assign send_rel = pwdata[4:0];

  // Encoder used when a send is ordered; it sees the relative number from the write.
  rif_encoder u_enc_send (
    .cfg(cfg_reg),
    .rel(send_rel),
    .entry(enc_entry),
    .msg(enc_msg),
    .cfg_err(enc_err)
  );

  // A second view with relative number zero feeds the message address and data read-back and the status error bit.
  rif_encoder u_enc_view (
    .cfg(cfg_reg),
    .rel(5'h00),
    .entry(),
    .msg(view_msg),
    .cfg_err(view_err)
  );

  // Address decode for the controller's own map.
  always_comb begin
    unique case (paddr)
      rif_pkg::ADDR_CTRL, rif_pkg::ADDR_INDEX, rif_pkg::ADDR_VECTOR, rif_pkg::ADDR_SEND,
      rif_pkg::ADDR_STATUS, rif_pkg::ADDR_REDIR_LO, rif_pkg::ADDR_REDIR_HI,
      rif_pkg::ADDR_MSI_ADDR, rif_pkg::ADDR_MSI_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Configuration writes land at the access edge.
  always_comb begin
    cfg_next = cfg_reg;
    if (access_phase && pwrite) begin
      if (paddr == rif_pkg::ADDR_CTRL) begin
        cfg_next.msi = pwdata[rif_pkg::CTRL_MSI_BIT];
        cfg_next.enc = rif_pkg::rif_enc_type'(pwdata[rif_pkg::CTRL_ENC_LSB +: 2]);
        cfg_next.log2n = pwdata[rif_pkg::CTRL_LOG2N_LSB +: 3];
        cfg_next.trig = pwdata[rif_pkg::CTRL_TRIG_BIT];
        cfg_next.mask = pwdata[rif_pkg::CTRL_MASK_BIT];
        cfg_next.msg_bcast = pwdata[rif_pkg::CTRL_BCAST_BIT];
      end else if (paddr == rif_pkg::ADDR_INDEX) begin
        cfg_next.index = pwdata[15:0];
      end else if (paddr == rif_pkg::ADDR_VECTOR) begin
        // Software writes the vector held by the referenced remap entry, so both agree.
        cfg_next.vector = pwdata[7:0];
      end
    end
  end

  // Settings register; reset leaves a single-vector router entry with index zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '{msi: 1'b0, enc: rif_pkg::RIF_ENC_HANDLE, log2n: 3'h0, trig: 1'b0,
                   mask: 1'b0, msg_bcast: 1'b0, index: rif_pkg::INDEX_RESET,
                   vector: rif_pkg::VECTOR_RESET};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Request launch and hand-off. A send while one is pending, or with a bad setting,
  // is dropped and raises the sticky error, so software never loses track silently.
  always_comb begin
    req_next = req_reg;
    req_valid_next = req_valid_reg;
    err_next = err_reg;
    sent_next = sent_reg;
    entry_next = enc_entry;
    if (req_valid_reg && req_ready) begin
      // The remapping side took the write on this edge.
      req_valid_next = 1'b0;
      sent_next = sent_reg + 8'h01;
    end
    if (access_phase && pwrite && paddr == rif_pkg::ADDR_STATUS && pwdata[rif_pkg::STAT_ERR_BIT]) begin
      // Write one clears the error flag; a new error in the same cycle wins below.
      err_next = 1'b0;
    end
    // Only one request may be outstanding, so a second send must wait on software.
    if (wr_send) begin
      if (req_valid_reg || enc_err) begin
        err_next = 1'b1;
      end else begin
        req_next = enc_msg;
        req_valid_next = 1'b1;
      end
    end
  end

  // Request state registers; the entry resets to the encoding of the reset settings,
  // so its read-back agrees with the settings from the first cycle on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= '0;
      req_valid_reg <= 1'b0;
      err_reg <= 1'b0;
      sent_reg <= 8'h00;
      entry_reg <= rif_pkg::ENTRY_RESET;
    end else begin
      req_reg <= req_next;
      req_valid_reg <= req_valid_next;
      err_reg <= err_next;
      sent_reg <= sent_next;
      entry_reg <= entry_next;
    end
  end

  // Read data is prepared in the setup phase so it is stable from a flop in the access phase.
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      prdata_next = 32'h0;
      pslverr_next = !mapped;
      if (!pwrite) begin
        unique case (paddr)
          rif_pkg::ADDR_CTRL: begin
            prdata_next[rif_pkg::CTRL_MSI_BIT] = cfg_reg.msi;
            prdata_next[rif_pkg::CTRL_ENC_LSB +: 2] = cfg_reg.enc;
            prdata_next[rif_pkg::CTRL_LOG2N_LSB +: 3] = cfg_reg.log2n;
            prdata_next[rif_pkg::CTRL_TRIG_BIT] = cfg_reg.trig;
            prdata_next[rif_pkg::CTRL_MASK_BIT] = cfg_reg.mask;
            prdata_next[rif_pkg::CTRL_BCAST_BIT] = cfg_reg.msg_bcast;
          end
          rif_pkg::ADDR_INDEX: prdata_next[15:0] = cfg_reg.index;
          rif_pkg::ADDR_VECTOR: prdata_next[7:0] = cfg_reg.vector;
          rif_pkg::ADDR_STATUS: begin
            prdata_next[rif_pkg::STAT_BUSY_BIT] = req_valid_reg;
            prdata_next[rif_pkg::STAT_ERR_BIT] = err_reg | view_err;
            prdata_next[rif_pkg::STAT_CNT_LSB +: 8] = sent_reg;
          end
          rif_pkg::ADDR_REDIR_LO: prdata_next = entry_reg[31:0];
          rif_pkg::ADDR_REDIR_HI: prdata_next = entry_reg[63:32];
          rif_pkg::ADDR_MSI_ADDR: prdata_next = view_msg.addr;
          rif_pkg::ADDR_MSI_DATA: prdata_next = view_msg.data;
          default: prdata_next = 32'h0;
        endcase
      end
    end else if (access_phase) begin
      pslverr_next = pslverr_reg;
    end
  end

  // Read data and error flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // The slave answers in the first access cycle; no wait states. Tying ready high
  // means a write can never stall the bus, so every writable register takes writes at once.
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && access_phase;
  assign req_valid = req_valid_reg;
  assign req_addr = req_reg.addr;
  assign req_data = req_reg.data;

  // Checks on what this controller drives. The remapping side's own duties are left
  // to its model, since this block cannot see the remap table or its faults.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_send_ok;
    wr_send && !req_valid_reg && !enc_err;
  endsequence

  sequence s_issue;
    req_valid_reg && $stable(sent_reg);
  endsequence

  chk_send_issue: assert property (s_send_ok |=> s_issue) else $error("Good send did not raise a request.");
  chk_hold_req: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_data))
    else $error("Request changed before acceptance.");
  chk_msg_id: assert property (req_valid |-> req_addr[31:20] == 12'hfee) else $error("Address identifier wrong.");
  chk_msi_flags: assert property (s_send_ok ##0 cfg_reg.msi |=> req_addr[4] && req_addr[3])
    else $error("Message request lacks format or subhandle-valid bit.");
  chk_router_shv: assert property (s_send_ok ##0 !cfg_reg.msi |=> !req_addr[3] && req_addr[4])
    else $error("Router request has subhandle-valid set.");
  chk_msi_index: assert property (s_send_ok ##0 cfg_reg.msi && cfg_reg.enc == rif_pkg::RIF_ENC_HANDLE
    |=> {req_addr[2], req_addr[19:5]} == $past(cfg_reg.index) && req_data == 32'h0)
    else $error("Message index placement wrong.");
  chk_multi_data: assert property (s_send_ok ##0 cfg_reg.enc == rif_pkg::RIF_ENC_MULTI
    |=> req_data == {27'h0, $past(send_rel)} && ($past(send_rel) >> $past(cfg_reg.log2n)) == 5'h00)
    else $error("Multi-vector payload wrong.");
  chk_entry_map: assert property (entry_reg[63:49] == $past(cfg_reg.index[14:0]) &&
    entry_reg[11] == $past(cfg_reg.index[15]) && entry_reg[48] && entry_reg[10:8] == 3'h0)
    else $error("Redirection entry layout wrong.");
  chk_entry_trig: assert property (entry_reg[15] == $past(cfg_reg.trig) && entry_reg[7:0] == $past(cfg_reg.vector))
    else $error("Entry trigger or vector differs from settings.");
  chk_err_refuse: assert property (wr_send && enc_err && !req_valid_reg |=> err_reg && !req_valid_reg)
    else $error("Bad send was not refused.");

  // A router request carries the vector as its whole payload.
  chk_router_data: assert property (s_send_ok ##0 !cfg_reg.msi
    |=> req_data == {24'h0, $past(cfg_reg.vector)})
    else $error("Router payload differs from the vector.");

  // The router form splits the index over address bit 2 and bits 19:5.
  chk_router_index: assert property (s_send_ok ##0 !cfg_reg.msi
    |=> {req_addr[2], req_addr[19:5]} == $past(cfg_reg.index))
    else $error("Router index placement wrong.");

  // With the subhandle form the handle is zero and the index rides in the payload.
  chk_sub_form: assert property (s_send_ok ##0 cfg_reg.msi && cfg_reg.enc == rif_pkg::RIF_ENC_SUB
    |=> {req_addr[2], req_addr[19:5]} == 16'h0000 && req_data == {16'h0000, $past(cfg_reg.index)})
    else $error("Subhandle form wrong.");

  // The upper payload half is never owned by the source, so it stays zero.
  chk_data_upper: assert property (req_valid |-> req_data[31:16] == 16'h0000)
    else $error("Payload upper half not zero.");

  // The mask bit keeps its ordinary place and meaning in the entry.
  chk_entry_mask: assert property (entry_reg[16] == $past(cfg_reg.mask))
    else $error("Entry mask differs from settings.");

  // A send that meets a pending request is dropped and flagged, and the pending one is kept.
  chk_busy_refuse: assert property (wr_send && req_valid_reg |=> err_reg && $stable(req_addr))
    else $error("Send during a pending request was not refused.");

  // Acceptance ends the request and counts it; no new send can slip in at that edge.
  chk_accept_end: assert property (req_valid && req_ready
    |=> !req_valid && sent_reg == $past(sent_reg) + 8'h01)
    else $error("Accepted request did not end or was not counted.");

endmodule // rif_source_ctrl

//--- rif_remap_model.sv
// Behavioural model of the remapping hardware that takes doubleword interrupt writes.
// Assumes the request port shares pclk and presetn with the source controller.
`timescale 1ns/10ps
module rif_remap_model #(
  parameter int TABLE_SIZE = 65536,
  parameter logic EXT_ADDR_CAP = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_data,
  output logic req_ready,
  output logic [7:0] acc_cnt,
  output logic [31:0] last_addr,
  output logic [31:0] last_data,
  output logic [31:0] last_index,
  output logic fault,
  output logic ext_addr_cap
);
  logic [31:0] lfsr_reg; // Pattern that decides when ready stalls.
  logic [15:0] handle; // Handle decoded from the address.
  logic [31:0] index; // Remap index computed from handle and subhandle.
  logic bad; // The request would be blocked as a fault.

  // Decode the request as it stands; a real unit would do this at acceptance too.
  always_comb begin
    handle = {req_addr[2], req_addr[19:5]};
    index = req_addr[3] ? 32'(handle) + 32'(req_data[15:0]) : 32'(handle);
    bad = (req_addr[31:20] != 12'hfee) || !req_addr[4];
    bad = bad || (index >= TABLE_SIZE);
  end

  // Ready stalls at random, so the controller must hold its request for many cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_reg <= 32'h0000_1d2b;
      req_ready <= 1'b0;
      acc_cnt <= 8'h00;
      last_addr <= 32'h0000_0000;
      last_data <= 32'h0000_0000;
      last_index <= 32'h0000_0000;
      fault <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      req_ready <= !hold && lfsr_reg[0];
      // The whole doubleword is taken at the accepting edge.
      if (req_valid && req_ready) begin
        acc_cnt <= acc_cnt + 8'h01;
        last_addr <= req_addr;
        last_data <= req_data;
        last_index <= index;
        // The fault report is a flag of the model's own; it is never sent as a request
        // and so never passes through the index decode above.
        fault <= bad;
      end
    end
  end

  // Capability flag for the extended addressing mode; software reads it before turning the mode on.
  assign ext_addr_cap = EXT_ADDR_CAP;
endmodule // rif_remap_model

//--- tb_top.sv
// Self-checking bench for the remappable interrupt source controller.
// Assumes the remapping model on the request port and an APB master made of tasks.
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, hold, fault, er, ext_cap;
  logic [7:0] paddr, acc_cnt;
  logic [31:0] pwdata, prdata, req_addr, req_data, last_addr, last_data, last_index, seed, rd;
  logic [8:0] c; // Random control word.
  logic [4:0] rel; // Random relative number.
  int miscompares, checks_done, sent;

  rif_source_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready));
  rif_remap_model model (.pclk(pclk), .presetn(presetn), .hold(hold), .req_valid(req_valid),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .acc_cnt(acc_cnt),
    .last_addr(last_addr), .last_data(last_data), .last_index(last_index), .fault(fault),
    .ext_addr_cap(ext_cap));

  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Galois shift register for repeatable stimulus.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  // A send is refused for illegal encodings, spare relative numbers or an index overflow.
  function automatic logic exp_err(input logic [8:0] k, input logic [15:0] idx, input logic [4:0] r);
    logic [16:0] top;
    top = 17'(idx) + (17'h1 << k[5:3]) - 17'h1;
    if (!k[0]) return (k[2:1] != 2'b00) || (r != 5'h00);
    if (k[2:1] == 2'b11) return 1'b1;
    if (k[2:1] != 2'b10) return r != 5'h00;
    return (k[5:3] > 3'h5) || (32'(r) >= (32'h1 << k[5:3])) || (top > 17'h0ffff);
  endfunction

  // Address: identifier, handle split over 19:5 and 2, format bit, flag only for messages.
  function automatic logic [31:0] exp_addr(input logic [8:0] k, input logic [15:0] idx);
    logic [15:0] h;
    h = (k[0] && k[2:1] == 2'b01) ? 16'h0000 : idx;
    return {12'hfee, h[14:0], 1'b1, k[0], h[15], 2'b00};
  endfunction

  // Data: vector for the router, subhandle for messages.
  function automatic logic [31:0] exp_data(input logic [8:0] k, input logic [15:0] idx,
                                           input logic [7:0] v, input logic [4:0] r);
    if (!k[0]) return {24'h0, v};
    if (k[2:1] == 2'b01) return {16'h0, idx};
    if (k[2:1] == 2'b10) return {27'h0, r};
    return 32'h0000_0000;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer: setup, then access until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    // Read data and the error flag are taken at the edge that completes the access.
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never drives psel again in this time step.
    @(posedge pclk);
  endtask

  // Wait until the model has accepted every send so far.
  task automatic wait_sent();
    int n;
    n = 0;
    while (acc_cnt !== 8'(sent) && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      stop_test();
    end
  endtask

  // Program one setting, inspect the entry of a router setting, send once and judge the outcome.
  task automatic trial(input logic [8:0] k, input logic [15:0] idx, input logic [7:0] v, input logic [4:0] r);
    logic e;
    e = exp_err(k, idx, r);
    apb(1'b1, rif_pkg::ADDR_CTRL, {23'h0, k});
    apb(1'b1, rif_pkg::ADDR_INDEX, {16'h0, idx});
    apb(1'b1, rif_pkg::ADDR_VECTOR, {24'h0, v});
    if (!k[0]) begin
      apb(1'b0, rif_pkg::ADDR_REDIR_LO, 32'h0);
      check(rd & 32'h0001_8fff, {15'h0, k[7], k[6], 3'h0, idx[15], 3'h0, v});
      apb(1'b0, rif_pkg::ADDR_REDIR_HI, 32'h0);
      check(rd & 32'hffff_0000, {idx[14:0], 1'b1, 16'h0});
    end
    apb(1'b1, rif_pkg::ADDR_STATUS, 32'h0000_0002);
    apb(1'b1, rif_pkg::ADDR_SEND, {27'h0, r});
    check({31'h0, er}, 32'h0);
    if (!e) begin
      sent++;
      wait_sent();
      check(last_addr, exp_addr(k, idx));
      check(last_data, exp_data(k, idx, v, r));
      check(last_index, (k[0] && k[2:1] == 2'b10) ? 32'(idx) + 32'(r) : 32'(idx));
      check({31'h0, fault}, 32'h0);
    end
    apb(1'b0, rif_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[1]}, {31'h0, e});
    check({24'h0, rd[15:8]}, 32'(8'(sent)));
  endtask

  // Reset, register checks, corner cases, a refused back-to-back send, then random traffic.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold = 1'b0;
    miscompares = 0;
    checks_done = 0;
    sent = 0;
    seed = 32'ha0bf;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({31'h0, req_valid}, 32'h0);
    check({31'h0, ext_cap}, 32'h1);
    apb(1'b0, rif_pkg::ADDR_CTRL, 32'h0);
    check(rd, rif_pkg::CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'h44, 32'hffff_ffff);
    check({31'h0, er}, 32'h1);
    apb(1'b0, rif_pkg::ADDR_SEND, 32'h0);
    check(rd, 32'h0);
    trial(9'h000, 16'h0000, 8'h00, 5'h00);
    trial(9'h003, 16'h1234, 8'h11, 5'h00);
    trial(9'h005, 16'h4321, 8'h22, 5'h00);
    trial(9'h02d, 16'hffe0, 8'h33, 5'h1f);
    trial(9'h02d, 16'hffe1, 8'h33, 5'h00);
    trial(9'h035, 16'h0100, 8'h44, 5'h00);
    trial(9'h015, 16'h0200, 8'h55, 5'h04);
    trial(9'h007, 16'h0300, 8'h66, 5'h00);
    trial(9'h002, 16'h0400, 8'h77, 5'h00);
    trial(9'h1c0, 16'h8000, 8'h5a, 5'h00);
    // The model stalls, so the second send meets a pending request and is refused.
    hold <= 1'b1;
    apb(1'b1, rif_pkg::ADDR_SEND, 32'h0);
    apb(1'b1, rif_pkg::ADDR_SEND, 32'h0);
    apb(1'b0, rif_pkg::ADDR_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h3);
    hold <= 1'b0;
    sent++;
    wait_sent();
    check(last_addr, {12'hfee, 15'h0, 1'b1, 1'b0, 1'b1, 2'b00});
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      c = seed[8:0];
      rel = seed[13:9];
      if (seed[31]) rel = (c[0] && c[2:1] == 2'b10) ? rel & 5'((32'h1 << c[5:3]) - 1) : 5'h00;
      seed = lfsr(seed);
      trial(c, seed[15:0], seed[23:16], rel);
    end
    stop_test();
  end
endmodule // tb_top
